/* File: lat_pkg.sv */
// Constants, register map and state type for the line averaging and test pattern block.
package lat_pkg;
  localparam int PIX_W    = 10;      // Widest pixel format carried on the output.
  localparam int IDX_W    = 13;      // Pixel index width, enough for a full line.
  localparam int LINE_MAX = 8160;    // Nominal and largest line length in pixels.

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LEN    = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_DARK   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Field positions in the control register.
  localparam int CTRL_AVG_BIT  = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_DUAL_BIT = 8;
  localparam int CTRL_TEN_BIT  = 9;
  localparam int CTRL_FREE_BIT = 12;
  localparam int CTRL_DARK_BIT = 13;

  // Field positions in the status register.
  localparam int STAT_PAIR_BIT  = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_LINES_LSB = 16;

  // Reset values.
  localparam logic [31:0]      CTRL_RST   = 32'h0000_0000;
  localparam logic [IDX_W-1:0] LEN_RST    = 13'h1FE0;
  localparam logic [15:0]      PERIOD_RST = 16'h0800;
  localparam logic [PIX_W-1:0] DARK_RST   = 10'h000;

  // Test pattern selector codes.
  localparam logic [2:0] TP_OFF   = 3'h0;
  localparam logic [2:0] TP_FIXED = 3'h1;
  localparam logic [2:0] TP_MOVE  = 3'h2;
  localparam logic [2:0] TP_BLACK = 3'h3;
  localparam logic [2:0] TP_GRAY  = 3'h4;

  // Fixed pixel levels.
  localparam logic [PIX_W-1:0] GRAY8   = 10'h040;
  localparam logic [PIX_W-1:0] GRAY10  = 10'h100;
  localparam logic [PIX_W-1:0] PIX_MAX = 10'h3FF;

  // Line sequencer states.
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CAPT = 2'b01,
    ST_SEND = 2'b10
  } state_t;
endpackage

/* File: line_average_test_pattern.sv */
// Line averaging, test line generation and pixel output toward the frame grabber.
module line_average_test_pattern
  import lat_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output wire logic [31:0]                prdata,
  output wire logic                       pready,
  output wire logic                       pslverr,
  input  wire logic                       line_trigger_input,
  input  wire logic                       pixel_clk_in,
  input  wire logic                       sensor_valid,
  input  wire logic [lat_pkg::PIX_W-1:0]  sensor_data,
  output wire logic                       line_valid,
  output wire logic [lat_pkg::PIX_W-1:0]  pix_a,
  output wire logic [lat_pkg::PIX_W-1:0]  pix_b,
  output wire logic                       pix_clk_out
);
  import lat_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Halves the sum of two pixels; the dropped low bit is the truncation.
  function automatic logic [PIX_W-1:0] avg2(input logic [PIX_W-1:0] a, input logic [PIX_W-1:0] b);
    logic [PIX_W:0] sum;
    sum  = {1'b0, a} + {1'b0, b};
    avg2 = sum[PIX_W:1];
  endfunction

  // Builds one test pixel from its zero-based index and the line count.
  // Nothing here looks at exposure timing, so only mode, ten-bit flag, index and line matter.
  function automatic logic [PIX_W-1:0] pattern(input logic [2:0] mode, input logic [IDX_W-1:0] k,
                                               input logic [7:0] line, input logic ten);
    logic [7:0] v8;
    v8 = 8'h00;
    pattern = 10'h000;
    unique case (mode)
      TP_FIXED: v8 = k[0] ? (8'hFF - k[8:1]) : k[8:1];
      TP_MOVE:  v8 = k[7:0] + line;
      default:  v8 = 8'h00;
    endcase
    if (mode == TP_GRAY)
      pattern = ten ? GRAY10 : GRAY8;
    else
      pattern = ten ? {v8, 2'b00} : {2'b00, v8};
  endfunction

  // Correction stage shared by live and test data, saturating at full scale.
  function automatic logic [PIX_W-1:0] correct(input logic [PIX_W-1:0] v, input logic en,
                                               input logic [PIX_W-1:0] ofs);
    logic [PIX_W:0] s;
    s = {1'b0, v} + {1'b0, (en ? ofs : DARK_RST)};
    correct = s[PIX_W] ? PIX_MAX : s[PIX_W-1:0];
  endfunction

  // Software state.
  logic [31:0]      ctrl_q;          // Mode fields and enables.
  logic [IDX_W-1:0] len_q;           // Pixels per output line.
  logic [15:0]      period_q;        // Free-run ticks come every period_q + 1 core cycles.
  logic [PIX_W-1:0] dark_q;          // Dark correction level.
  logic [31:0]      prdata_q;        // Read data, loaded in the setup cycle.
  logic             pready_q;        // High in the first access cycle.
  logic             pslverr_q;       // Error for an unmapped address.

  // Synchronisers and edge history for the two pins.
  logic             trig_s1_q, trig_s2_q, trig_s3_q;
  logic             pclk_s1_q, pclk_s2_q, pclk_s3_q;

  // Sequencer state.
  state_t           state_q;
  logic             pair_q;          // High once the first line of a pair is stored.
  logic             avg_old_q;       // Averaging enable of the previous cycle.
  logic [IDX_W-1:0] cap_idx_q;       // Capture write index.
  logic [IDX_W-1:0] out_idx_q;       // Next pixel to send.
  logic [15:0]      free_cnt_q;      // Free-run tick counter.
  logic [7:0]       line_cnt_q;      // Test line count for the moving gradient.
  logic [15:0]      lines_out_q;     // Lines sent, wraps.
  logic [2:0]       l_mode_q;        // Pattern mode latched at line start.
  logic             l_dual_q;        // Dual output latched at line start.
  logic             l_ten_q;         // Ten-bit output latched at line start.
  logic             l_dark_q;        // Dark correction latched at line start.
  logic             line_valid_q;
  logic [PIX_W-1:0] pix_a_q, pix_b_q;
  logic             pix_clk_q;
  logic [PIX_W-1:0] mem_q [LINE_MAX]; // Line buffer for every captured line; the second line of a pair overwrites it with the average.

  // Register field decode.
  wire              avg_en   = ctrl_q[CTRL_AVG_BIT];
  wire [2:0]        tp_mode  = ctrl_q[CTRL_MODE_LSB +: 3];
  wire              free_run = ctrl_q[CTRL_FREE_BIT];

  // APB decode: setup loads read data, the access cycle commits writes.
  wire              setup    = psel && !penable;
  wire              wr_en    = psel && penable && pready_q && pwrite;
  wire              hit      = (paddr == OFS_CTRL) || (paddr == OFS_LEN) || (paddr == OFS_PERIOD)
                               || (paddr == OFS_DARK) || (paddr == OFS_STATUS);
  wire [31:0]       status   = {lines_out_q, 13'h0000, state_q, pair_q};
  wire [31:0]       rd_mux   = (paddr == OFS_CTRL)   ? ctrl_q :
                               (paddr == OFS_LEN)    ? {19'h0_0000, len_q} :
                               (paddr == OFS_PERIOD) ? {16'h0000, period_q} :
                               (paddr == OFS_DARK)   ? {22'h00_0000, dark_q} :
                               (paddr == OFS_STATUS) ? status : 32'h0000_0000;
  // Lengths above the buffer are clamped so the index never leaves it.
  wire [IDX_W-1:0]  len_wr   = (pwdata[31:0] > 32'(LINE_MAX)) ? LEN_RST : pwdata[IDX_W-1:0];

  // Line start sources and pixel clock edge.
  wire              trig_edge = trig_s2_q && !trig_s3_q;
  wire              free_tick = (free_cnt_q >= period_q);
  wire              line_go   = free_run ? free_tick : trig_edge;
  wire              pix_edge  = pclk_s2_q && !pclk_s3_q;
  wire              test_on   = (tp_mode != TP_OFF);
  wire              avg_rise  = avg_en && !avg_old_q;

  // Capture path: the second line of a pair is merged with the stored first.
  wire              cap_done  = (cap_idx_q >= len_q);
  wire              cap_we    = (state_q == ST_CAPT) && sensor_valid && !cap_done;
  wire [PIX_W-1:0]  cap_wval  = (avg_en && pair_q) ? avg2(mem_q[cap_idx_q], sensor_data)
                                                   : sensor_data;
  wire              hold_line = avg_en && !pair_q;  // First line of a pair stays silent.

  // Output path: two pixels per clock in dual mode.
  wire [IDX_W-1:0]  step      = l_dual_q ? 13'h0002 : 13'h0001;
  wire [IDX_W-1:0]  idx_b     = out_idx_q + 13'h0001;
  wire              send_more = (out_idx_q < len_q);
  wire              b_ok      = l_dual_q && (idx_b < len_q);
  wire [PIX_W-1:0]  raw_a     = (l_mode_q != TP_OFF) ? pattern(l_mode_q, out_idx_q, line_cnt_q, l_ten_q)
                                                     : mem_q[out_idx_q];
  wire [PIX_W-1:0]  raw_b     = (l_mode_q != TP_OFF) ? pattern(l_mode_q, idx_b, line_cnt_q, l_ten_q)
                                                     : mem_q[b_ok ? idx_b : out_idx_q];
  wire [PIX_W-1:0]  out_a     = correct(raw_a, l_dark_q, dark_q);
  wire [PIX_W-1:0]  out_b     = b_ok ? correct(raw_b, l_dark_q, dark_q) : DARK_RST;

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign line_valid  = line_valid_q;
  assign pix_a       = pix_a_q;
  assign pix_b       = pix_b_q;
  assign pix_clk_out = pix_clk_q;

  // APB slave with one access cycle; unmapped addresses answer with an error.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q    <= CTRL_RST;
      len_q     <= LEN_RST;
      period_q  <= PERIOD_RST;
      dark_q    <= DARK_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit;
      if (setup)
        prdata_q <= rd_mux;
      if (wr_en && (paddr == OFS_CTRL))
        ctrl_q <= pwdata;
      if (wr_en && (paddr == OFS_LEN))
        len_q <= len_wr;
      if (wr_en && (paddr == OFS_PERIOD))
        period_q <= pwdata[15:0];
      if (wr_en && (paddr == OFS_DARK))
        dark_q <= pwdata[PIX_W-1:0];
    end
  end

  // Two-stage synchronisers; edges are found only between the second and third stage.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {trig_s1_q, trig_s2_q, trig_s3_q} <= 3'h0;
      {pclk_s1_q, pclk_s2_q, pclk_s3_q} <= 3'h0;
      pix_clk_q <= 1'b0;
    end
    else
    begin
      {trig_s1_q, trig_s2_q, trig_s3_q} <= {line_trigger_input, trig_s1_q, trig_s2_q};
      {pclk_s1_q, pclk_s2_q, pclk_s3_q} <= {pixel_clk_in, pclk_s1_q, pclk_s2_q};
      // The forwarded clock rises in the same cycle as the new pixel data.
      pix_clk_q <= pclk_s2_q;
    end
  end

  // Free-run tick counter, runs whether or not free-run is selected.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      free_cnt_q <= 16'h0000;
    else
      free_cnt_q <= free_tick ? 16'h0000 : free_cnt_q + 16'h0001;
  end

  // Line buffer writes; data storage needs no reset.
  always_ff @(posedge core_clk)
  begin
    if (cap_we)
      mem_q[cap_idx_q] <= cap_wval;
  end

  // Line sequencer: wait, capture or generate, then send on pixel clock edges.
  // Starts that arrive while a line is busy are dropped, which bounds the line rate.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q      <= ST_IDLE;
      pair_q       <= 1'b0;
      avg_old_q    <= 1'b0;
      cap_idx_q    <= '0;
      out_idx_q    <= '0;
      line_cnt_q   <= 8'h00;
      lines_out_q  <= 16'h0000;
      {l_mode_q, l_dual_q, l_ten_q, l_dark_q} <= 6'h00;
      line_valid_q <= 1'b0;
      pix_a_q      <= DARK_RST;
      pix_b_q      <= DARK_RST;
    end
    else
    begin
      avg_old_q <= avg_en;
      unique case (state_q)
        ST_IDLE:
        begin
          if (line_go)
          begin
            l_mode_q  <= tp_mode;
            l_dual_q  <= ctrl_q[CTRL_DUAL_BIT];
            l_ten_q   <= ctrl_q[CTRL_TEN_BIT];
            l_dark_q  <= ctrl_q[CTRL_DARK_BIT];
            cap_idx_q <= '0;
            out_idx_q <= '0;
            state_q   <= test_on ? ST_SEND : ST_CAPT;
          end
        end
        ST_CAPT:
        begin
          if (cap_we)
            cap_idx_q <= cap_idx_q + 13'h0001;
          if (cap_done && hold_line)
          begin
            pair_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
          else if (cap_done)
          begin
            pair_q  <= 1'b0;
            state_q <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (pix_edge && send_more)
          begin
            line_valid_q <= 1'b1;
            pix_a_q      <= out_a;
            pix_b_q      <= out_b;
            out_idx_q    <= out_idx_q + step;
          end
          else if (pix_edge)
          begin
            line_valid_q <= 1'b0;
            pix_a_q      <= DARK_RST;
            pix_b_q      <= DARK_RST;
            lines_out_q  <= lines_out_q + 16'h0001;
            if (l_mode_q != TP_OFF)
              line_cnt_q <= line_cnt_q + 8'h01;
            state_q      <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
      // Turning averaging on makes the next capture the first of a pair.
      if (avg_rise)
        pair_q <= 1'b0;
    end
  end

  a_pair_silent: assert property ((state_q == ST_CAPT) && cap_done && hold_line && !avg_rise
    |=> (state_q == ST_IDLE) && !line_valid_q && pair_q)
    else $error("first line of a pair was not held back");
  a_second_sends: assert property ((state_q == ST_CAPT) && cap_done && avg_en && pair_q
    |=> (state_q == ST_SEND) && !pair_q)
    else $error("second line of a pair did not start sending");
  a_avg_trunc: assert property (cap_we && avg_en && pair_q
    |-> cap_wval == ((11'(mem_q[cap_idx_q]) + 11'(sensor_data)) >> 1))
    else $error("averaged pixel is not the truncated half sum");
  a_first_pixel: assert property ($rose(line_valid_q)
    |-> $past(pix_edge) && (out_idx_q == step))
    else $error("line valid rose without pixel one");
  a_valid_fall: assert property ($fell(line_valid_q)
    |-> $past(out_idx_q) >= $past(len_q) && state_q == ST_IDLE)
    else $error("line valid fell before the line was complete");
  a_dual_step: assert property ((state_q == ST_SEND) && pix_edge && send_more && l_dual_q
    |=> out_idx_q == $past(out_idx_q) + 13'h0002)
    else $error("dual output did not advance by two pixels");
  a_black_zero: assert property (line_valid_q && (l_mode_q == TP_BLACK) && !l_dark_q
    |-> (pix_a_q == 10'h000) && (pix_b_q == 10'h000))
    else $error("black pattern pixel is not zero");
  a_gray_level: assert property (line_valid_q && (l_mode_q == TP_GRAY) && !l_dark_q
    |-> pix_a_q == (l_ten_q ? 10'h100 : 10'h040))
    else $error("gray pattern level is wrong");
  a_move_shift: assert property ((state_q == ST_SEND) && pix_edge && !send_more
    && (l_mode_q != TP_OFF) |=> line_cnt_q == $past(line_cnt_q) + 8'h01)
    else $error("moving gradient did not shift after a test line");
  a_avg_restart: assert property (avg_rise |=> !pair_q)
    else $error("enabling averaging did not restart pair counting");
  a_test_skips: assert property ((state_q == ST_IDLE) && line_go && test_on
    |=> state_q == ST_SEND)
    else $error("test line start did not go straight to sending");
endmodule

/* File: grabber_model.sv */
// Frame grabber model: makes the pixel clock and collects the pixels of every line.
module grabber_model
  import lat_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       run,
  input  wire logic                       line_valid,
  input  wire logic [lat_pkg::PIX_W-1:0]  pix_a,
  input  wire logic [lat_pkg::PIX_W-1:0]  pix_b,
  input  wire logic                       pix_clk_out,
  output var  logic                       pixel_clk_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PIX_W-1:0] qa[$];          // First pixel of each received word.
  logic [PIX_W-1:0] qb[$];          // Second pixel of each received word.
  int               lines = 0;      // Lines seen to end.
  logic             clk_seen = 1'b0; // Pixel clock one core cycle ago.
  logic             lv_seen = 1'b0;  // Line valid one core cycle ago.

  // The clock stands still while no line is wanted, so a stray line cannot slip out unseen.
  initial pixel_clk_in = 1'b0;
  always
  begin
    #400;
    pixel_clk_in = run ? ~pixel_clk_in : 1'b0;
  end

  // Data are taken one core cycle after the pixel clock rises, once they have settled.
  always @(posedge core_clk)
  begin
    clk_seen <= pix_clk_out;
    lv_seen  <= line_valid;
    if (pix_clk_out && !clk_seen && line_valid)
    begin
      qa.push_back(pix_a);
      qb.push_back(pix_b);
    end
    if (lv_seen && !line_valid)
      lines++;
  end
endmodule

/* File: tb_top.sv */
// Testbench for the line averaging and test pattern block.
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %s exp %0h got %0h", what, exp, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lat_pkg::*;
  localparam int LEN = 5;           // Short odd line keeps runs brief and tests the dual tail.
  logic             core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdat;
  logic             line_trigger_input, pixel_clk_in, sensor_valid, line_valid, pix_clk_out;
  logic [PIX_W-1:0] sensor_data, pix_a, pix_b;
  logic             run, rerr;
  logic [PIX_W-1:0] exq[LEN];       // Expected pixels of the next line.
  int               fail_count = 0;
  int               n_compared = 0;
  int               cycles = 0;

  line_average_test_pattern i_line_average_test_pattern (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_trigger_input(line_trigger_input),
    .pixel_clk_in(pixel_clk_in), .sensor_valid(sensor_valid), .sensor_data(sensor_data),
    .line_valid(line_valid), .pix_a(pix_a), .pix_b(pix_b), .pix_clk_out(pix_clk_out));
  grabber_model i_grab (.core_clk(core_clk), .run(run), .line_valid(line_valid), .pix_a(pix_a),
    .pix_b(pix_b), .pix_clk_out(pix_clk_out), .pixel_clk_in(pixel_clk_in));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run through the same report.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  // One APB transfer; an idle cycle follows so psel is never assigned twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge core_clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    if (n == 16)
      fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", exp, rdat)
    `CHK("pslverr", eerr, rerr)
  endtask

  function automatic logic [31:0] ctl(input logic avg, input logic [2:0] m, input logic dual,
                                      input logic ten, input logic free, input logic dark);
    return (32'(avg) << CTRL_AVG_BIT) | (32'(m) << CTRL_MODE_LSB) | (32'(dual) << CTRL_DUAL_BIT)
         | (32'(ten) << CTRL_TEN_BIT) | (32'(free) << CTRL_FREE_BIT)
         | (32'(dark) << CTRL_DARK_BIT);
  endfunction

  // Trigger cycle on the external pin: high then low, each long enough for the synchroniser.
  task automatic trig();
    line_trigger_input <= 1'b1;
    repeat (4) @(posedge core_clk);
    line_trigger_input <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // Runs the pixel clock until the grabber sees one line end.
  task automatic take_line();
    int l0;
    int n;
    l0 = i_grab.lines;
    n = 0;
    run <= 1'b1;
    while (i_grab.lines == l0 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    run <= 1'b0;
    if (n == 3000)
      fail_count++;
    repeat (10) @(posedge core_clk);
  endtask

  // Compares the collected words with exq; in dual mode an odd line ends with a zero partner.
  task automatic cmp(input logic dual);
    int w;
    w = dual ? (LEN + 1) / 2 : LEN;
    `CHK("words", w, i_grab.qa.size())
    for (int k = 0; k < LEN; k++)
      if (dual && k[0]) `CHK("pix_b", exq[k], i_grab.qb[k/2])
      else `CHK("pix_a", exq[k], i_grab.qa[dual ? k/2 : k])
    if (dual) `CHK("pix_b", 10'h000, i_grab.qb[LEN/2])
    else `CHK("pix_b", 10'h000, i_grab.qb[0])
    i_grab.qa.delete();
    i_grab.qb.delete();
  endtask

  // One generated line; expected values come from the pattern definitions alone.
  task automatic test_line(input logic [2:0] m, input logic ten, input int lc,
                           input logic dual, input logic [9:0] dk, input logic tg);
    logic [9:0] v;
    if (tg)
      trig();
    take_line();
    for (int k = 0; k < LEN; k++)
    begin
      case (m)
        TP_FIXED: v = k[0] ? 10'(255 - k[8:1]) : 10'(k[8:1]);
        TP_MOVE:  v = 10'((k + lc) % 256);
        TP_BLACK: v = 10'h000;
        default:  v = ten ? GRAY10 : GRAY8;
      endcase
      exq[k] = ((m == TP_FIXED || m == TP_MOVE) && ten) ? 10'(v << 2) : v + dk;
    end
    cmp(dual);
  endtask

  // One live line streamed at core rate; the first and second line of a pair carry different values.
  task automatic feed(input logic second);
    trig();
    for (int k = 0; k < LEN; k++)
    begin
      sensor_valid <= 1'b1;
      sensor_data <= second ? 10'(10'h005 + 3 * k) : 10'(10'h3F0 + k);
      @(posedge core_clk);
    end
    sensor_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  // After a first exposure nothing may come out even with the pixel clock running.
  // With chk low it only flushes a line that a free-run tick may have left pending.
  task automatic quiet(input logic chk);
    int l0;
    l0 = i_grab.lines;
    run <= 1'b1;
    repeat (120) @(posedge core_clk);
    run <= 1'b0;
    repeat (10) @(posedge core_clk);
    if (chk)
    begin
      `CHK("lines", l0, i_grab.lines)
      `CHK("words", 0, i_grab.qa.size())
    end
    i_grab.qa.delete();
    i_grab.qb.delete();
  endtask

  initial
  begin
    resetn = 1'b0;
    {psel, penable, pwrite, line_trigger_input, sensor_valid, run} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sensor_data = 10'h000;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFS_CTRL, CTRL_RST, 1'b0);
    rd(OFS_LEN, 32'h0000_1FE0, 1'b0);
    rd(OFS_PERIOD, 32'h0000_0800, 1'b0);
    rd(OFS_DARK, 32'h0000_0000, 1'b0);
    rd(OFS_STATUS, 32'h0000_0000, 1'b0);
    rd(8'h40, 32'h0000_0000, 1'b1);
    apb(1'b1, OFS_LEN, 32'h0000_FFFF);
    rd(OFS_LEN, 32'h0000_1FE0, 1'b0);
    apb(1'b1, OFS_LEN, LEN);
    apb(1'b1, OFS_CTRL, ctl(0, TP_MOVE, 0, 0, 0, 0));
    for (int lc = 0; lc < 2; lc++)
      test_line(TP_MOVE, 1'b0, lc, 1'b0, 10'h000, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, OFS_CTRL, ctl(0, 3'(1 + (i / 2) + (i > 1)), 0, i[0], 0, 0));
      test_line(3'(1 + (i / 2) + (i > 1)), i[0], 0, 1'b0, 10'h000, 1'b1);
    end
    apb(1'b1, OFS_CTRL, ctl(0, TP_FIXED, 1, 0, 0, 0));
    test_line(TP_FIXED, 1'b0, 0, 1'b1, 10'h000, 1'b1);
    apb(1'b1, OFS_DARK, 32'h0000_0005);
    apb(1'b1, OFS_CTRL, ctl(0, TP_BLACK, 0, 0, 0, 1));
    test_line(TP_BLACK, 1'b0, 0, 1'b0, 10'h005, 1'b1);
    apb(1'b1, OFS_PERIOD, 32'h0000_0014);
    apb(1'b1, OFS_CTRL, ctl(0, TP_GRAY, 0, 0, 1, 0));
    for (int i = 0; i < 2; i++)
      test_line(TP_GRAY, 1'b0, 0, 1'b0, 10'h000, 1'b0);
    apb(1'b1, OFS_CTRL, ctl(1, TP_OFF, 0, 1, 0, 0));
    quiet(1'b0);
    for (int k = 0; k < LEN; k++)
      exq[k] = 10'((11'(10'h3F0 + k) + 11'(10'h005 + 3 * k)) >> 1);
    feed(1'b0);
    quiet(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("pair", 1'b1, rdat[STAT_PAIR_BIT])
    `CHK("state", 2'h0, rdat[STAT_STATE_LSB +: 2])
    feed(1'b1);
    take_line();
    cmp(1'b0);
    feed(1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, ctl(1, TP_OFF, 1, 1, 0, 0));
    feed(1'b0);
    quiet(1'b1);
    feed(1'b1);
    take_line();
    cmp(1'b1);
    test_done();
  end
endmodule
